// file: rtl/adc_serial_if.sv
/*
 * conversion control and serial result port of a 14-bit sar converter.
 * assumes link pins are asynchronous, sclk well below clk_sys/4, and the
 * analog sample arrives as a digital word on analog_input.
 */
`default_nettype none
// Operation
// - in dsp mode pulse frame_sync_out when result msb appears on dout
// - chip-select high means shutdown, low means normal operation
// - chip-select falling edge wakes analog and enables command shifting
// - acquisition advances only on host serial clock edges; sar conversion steps on clk_sys
// - dout low until msb on falling edge 8 or 16
// - result shifted msb first as unsigned straight binary
// - dsp mode needs external clock; frame_sync_in pulse starts conversion
// - chip-select high then low returns track/hold to tracking
// - 16-bit mode acquisition lasts eleven and a half serial clocks
// - hold phase resolves sample to 14 bits by successive approximation
// - end-of-conversion low when ready with internal clock, high otherwise
module adc_serial_if
    import adc_serial_pkg::*;
(
    // clock and reset
    input  wire logic                               clk_sys,
    input  wire logic                               rst_n,
    // serial link pins
    input  wire logic                               cs_n,
    input  wire logic                               sclk,
    input  wire logic                               din,
    output logic                                    dout,
    output logic                                    dout_oe_n,
    output logic                                    eoc_n,
    input  wire logic                               frame_sync_in,
    output logic                                    frame_sync_out,
    input  wire logic                               transfer_width_select,
    // analog side
    input  wire logic [adc_serial_pkg::RESULT_W-1:0] analog_input,
    input  wire logic                               internal_clock_mode,
    // status
    output logic                                    shutdown,
    output logic                                    tracking,
    output logic [adc_serial_pkg::CMD_W-1:0]        command
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ACQ  = 4'b0010,
        ST_CONV = 4'b0100,
        ST_DONE = 4'b1000
    } phase_e;

    phase_e phase_r;
    logic [2:0] cs_s_r, sclk_s_r, fs_s_r;
    logic [1:0] din_s_r, sel_s_r;
    logic       cs_q, sclk_q, fs_q, din_q, sel_q;
    logic       cs_fall, cs_rise, sclk_rise, sclk_fall, fs_fall;
    logic       dsp_mode_r, wide_r, armed_r;
    logic [CNT_W-1:0]    fall_cnt_r;
    logic [CMD_W-1:0]    cmd_r;
    logic [RESULT_W-1:0] sample_r, shift_r, sar_result;
    logic                sar_start, sar_done;
    logic [CNT_W-1:0]    acq_end, data_edge, frame_len;

    // two-flop synchronisers, third stage only for edge finding
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cs_s_r   <= 3'h7;
            sclk_s_r <= 3'h0;
            fs_s_r   <= 3'h7;
            din_s_r  <= 2'h0;
            sel_s_r  <= 2'h0;
        end else begin
            cs_s_r   <= {cs_s_r[1:0], cs_n};
            sclk_s_r <= {sclk_s_r[1:0], sclk};
            fs_s_r   <= {fs_s_r[1:0], frame_sync_in};
            din_s_r  <= {din_s_r[0], din};
            sel_s_r  <= {sel_s_r[0], transfer_width_select};
        end
    end
    assign cs_q      = cs_s_r[1];
    assign sclk_q    = sclk_s_r[1];
    assign fs_q      = fs_s_r[1];
    assign din_q     = din_s_r[1];
    assign sel_q     = sel_s_r[1];
    assign cs_fall   = cs_s_r[2] & ~cs_q;
    assign cs_rise   = ~cs_s_r[2] & cs_q;
    assign sclk_rise = ~sclk_s_r[2] & sclk_q;
    assign sclk_fall = sclk_s_r[2] & ~sclk_q;
    assign fs_fall   = fs_s_r[2] & ~fs_q;

    assign acq_end   = wide_r ? ACQ_END_16 : ACQ_END_8;
    assign data_edge = wide_r ? DATA_EDGE_16 : DATA_EDGE_8;
    assign frame_len = wide_r ? FRAME_LEN_16 : FRAME_LEN_8;

    assign shutdown = cs_q;

    // sar start: the falling sclk edge that ends acquisition, in either mode
    assign sar_start = !cs_q && (phase_r == ST_ACQ) && sclk_fall && fall_cnt_r == acq_end - 6'h01;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_r    <= ST_IDLE;
            fall_cnt_r <= '0;
            dsp_mode_r <= 1'b0;
            wide_r     <= 1'b0;
            armed_r    <= 1'b1;
            sample_r   <= RESULT_RESET;
        end else if (cs_q) begin
            phase_r    <= ST_IDLE;
            fall_cnt_r <= '0;
            armed_r    <= 1'b1;    // high phase of cs re-arms tracking
        end else begin
            case (phase_r)
                ST_IDLE: begin
                    // dsp start only with external clock
                    if (armed_r && (cs_fall || (fs_fall && !internal_clock_mode))) begin
                        phase_r    <= ST_ACQ;
                        dsp_mode_r <= ~fs_q && !internal_clock_mode;
                        wide_r     <= sel_q;
                        fall_cnt_r <= '0;
                        armed_r    <= 1'b0;
                    end
                end
                ST_ACQ: begin
                    if (sclk_fall) begin
                        fall_cnt_r <= fall_cnt_r + 6'h01;
                        if (fall_cnt_r == acq_end - 6'h01) begin
                            sample_r <= analog_input; // track/hold opens
                            phase_r  <= ST_CONV;
                        end
                    end
                end
                ST_CONV, ST_DONE: begin
                    if (sclk_fall) begin
                        fall_cnt_r <= fall_cnt_r + 6'h01;
                        if (fall_cnt_r == frame_len - 6'h01) phase_r <= ST_IDLE;
                        else if (fall_cnt_r == data_edge - 6'h01) phase_r <= ST_DONE;
                    end
                end
                default: phase_r <= ST_IDLE;
            endcase
        end
    end

    assign tracking = (phase_r == ST_IDLE && armed_r) || phase_r == ST_ACQ;

    // sar steps on clk_sys once hold starts: too few serial edges remain for 14 bits
    sar_array u_sar (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .start   (sar_start),
        .step    (phase_r == ST_CONV),
        .sample  (sample_r),
        .result  (sar_result),
        .done    (sar_done)
    );

    // command shifts in on the first eight rising sclk edges of a frame while selected
    always_ff @(posedge clk_sys) begin
        if (!rst_n) cmd_r <= CMD_RESET;
        else if (!cs_q && phase_r != ST_IDLE && sclk_rise && fall_cnt_r < 6'h08)
            cmd_r <= {cmd_r[CMD_W-2:0], din_q};
    end
    assign command = cmd_r;

    // output shifter: low until data edge, then msb first on falling edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dout           <= 1'b0;
            shift_r        <= RESULT_RESET;
            frame_sync_out <= 1'b0;
        end else begin
            frame_sync_out <= 1'b0;
            if (cs_q || phase_r == ST_IDLE) begin
                dout <= 1'b0;
            end else if (sclk_fall) begin
                if (fall_cnt_r == data_edge - 6'h01) begin
                    dout           <= sar_result[RESULT_W-1];
                    shift_r        <= {sar_result[RESULT_W-2:0], 1'b0};
                    frame_sync_out <= dsp_mode_r;
                end else if (phase_r == ST_DONE) begin
                    dout    <= shift_r[RESULT_W-1];
                    shift_r <= {shift_r[RESULT_W-2:0], 1'b0};
                end else begin
                    dout <= 1'b0;
                end
            end
        end
    end
    assign dout_oe_n = cs_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) eoc_n <= EOC_RESET;
        else if (!internal_clock_mode || cs_q) eoc_n <= 1'b1;
        else if (sclk_fall && fall_cnt_r == data_edge - 6'h01) eoc_n <= 1'b0;
    end

    chk_shutdown_follows_cs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cs_q |-> shutdown ##1 phase_r == ST_IDLE)
        else $error("not in shutdown with chip-select high");
    chk_cs_fall_wakes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cs_fall && armed_r && phase_r == ST_IDLE) |=> phase_r == ST_ACQ)
        else $error("chip-select fall did not start frame");
    chk_no_sclk_no_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!sclk_fall && !cs_q && phase_r != ST_IDLE) |=> $stable(fall_cnt_r))
        else $error("frame advanced without serial clock");
    chk_dout_low_early: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (phase_r == ST_ACQ || phase_r == ST_CONV) |-> !dout)
        else $error("dout high before data edge");
    chk_msb_on_edge: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sclk_fall && !cs_q && phase_r != ST_IDLE && fall_cnt_r == data_edge - 6'h01)
        |=> dout == $past(sar_result[RESULT_W-1]))
        else $error("msb not presented on data edge");
    chk_fso_with_msb: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frame_sync_out |-> dsp_mode_r && phase_r == ST_DONE ##1 !frame_sync_out)
        else $error("frame sync out outside msb edge");
    chk_rearm_needs_cs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (phase_r == ST_IDLE && !armed_r && !cs_q) |=> phase_r == ST_IDLE)
        else $error("new frame without chip-select cycle");
    chk_eoc_ext_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!internal_clock_mode && !$past(internal_clock_mode)) |-> eoc_n)
        else $error("eoc low in external clock mode");
    chk_wide_acq_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sar_start) |-> fall_cnt_r == (wide_r ? 6'h0B : 6'h03))
        else $error("acquisition length wrong");

    // conversion and result shifting
    chk_conv_before_msb: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sclk_fall && !cs_q && phase_r == ST_CONV && fall_cnt_r == data_edge - 6'h01) |-> sar_done)
        else $error("conversion not finished at data edge");
    chk_sample_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (phase_r == ST_CONV) |=> $stable(sample_r))
        else $error("held sample changed during conversion");
    chk_acq_takes_sample: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sar_start |=> sample_r == $past(analog_input))
        else $error("sample not taken at acquisition end");
    chk_dout_zero_tail: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (phase_r == ST_DONE && fall_cnt_r >= data_edge + 6'h0E) |-> !dout)
        else $error("dout high after last result bit");
    chk_dout_on_fall_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!sclk_fall && !cs_q && phase_r != ST_IDLE) |=> $stable(dout))
        else $error("dout changed without falling serial clock");
    chk_frame_len_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sclk_fall && !cs_q && phase_r == ST_DONE && fall_cnt_r == frame_len - 6'h01) |=> phase_r == ST_IDLE)
        else $error("frame did not end after last falling edge");
    chk_tracking_off_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (phase_r == ST_CONV || phase_r == ST_DONE) |-> !tracking)
        else $error("tracking during hold");

    // command shifting, frame settings and end-of-conversion
    chk_cmd_hold_shutdown: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cs_q |=> $stable(command))
        else $error("command changed in shutdown");
    chk_cmd_shift_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!cs_q && phase_r != ST_IDLE && sclk_rise && fall_cnt_r < 6'h08)
        |=> command == {$past(command[CMD_W-2:0]), $past(din_q)})
        else $error("command bit not taken on rising edge");
    chk_width_latched: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (phase_r != ST_IDLE) |=> $stable(wide_r))
        else $error("transfer width changed inside frame");
    chk_dsp_ext_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(dsp_mode_r) |-> !$past(internal_clock_mode))
        else $error("dsp mode entered with internal clock");
    chk_eoc_low_at_msb: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (internal_clock_mode && !cs_q && sclk_fall && phase_r == ST_CONV && fall_cnt_r == data_edge - 6'h01)
        |=> !eoc_n)
        else $error("eoc not low with result ready");
    chk_eoc_high_shutdown: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cs_q |=> eoc_n)
        else $error("eoc low in shutdown");

    cov_spi_narrow: cover property (@(posedge clk_sys) disable iff (!rst_n)
        phase_r == ST_DONE && !wide_r && !dsp_mode_r);
    cov_spi_wide: cover property (@(posedge clk_sys) disable iff (!rst_n)
        phase_r == ST_DONE && wide_r);
    cov_dsp_frame: cover property (@(posedge clk_sys) disable iff (!rst_n) frame_sync_out);
    cov_eoc_low: cover property (@(posedge clk_sys) disable iff (!rst_n) !eoc_n);
    cov_wide_conv_done: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(sar_done) && wide_r);
endmodule
`default_nettype wire

// file: rtl/adc_serial_pkg.sv
/*
 * constants for the serial conversion interface of a 14-bit sar converter.
 * assumes a 200 MHz system clock sampling all link pins.
 */
`default_nettype none
package adc_serial_pkg;
    localparam int          RESULT_W        = 14;
    localparam int          CMD_W           = 8;
    localparam int          CNT_W           = 6;
    localparam logic [5:0]  DATA_EDGE_8     = 6'h08;
    localparam logic [5:0]  DATA_EDGE_16    = 6'h10;
    // acquisition ends on these falling edges: 3.5 or 11.5 clocks after the first rise
    localparam logic [5:0]  ACQ_END_8       = 6'h04;
    localparam logic [5:0]  ACQ_END_16      = 6'h0C;
    localparam logic [5:0]  FRAME_LEN_8     = 6'h18;
    localparam logic [5:0]  FRAME_LEN_16    = 6'h20;
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          ACQ_MIN_NS      = 729;
    localparam int          ACQ_MIN_CYC     = (ACQ_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic        EOC_RESET       = 1'b1;
    localparam logic [13:0] RESULT_RESET    = 14'h0000;
    localparam logic [7:0]  CMD_RESET       = 8'h06;
endpackage
`default_nettype wire

// file: rtl/sar_array.sv
/*
 * successive-approximation stepper: resolves a 14-bit sample one bit per step.
 * assumes step is the parent's hold-phase level, one step per clk_sys cycle.
 */
`default_nettype none
module sar_array
    import adc_serial_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    // control
    input  wire logic                start,
    input  wire logic                step,
    input  wire logic [RESULT_W-1:0] sample,
    // result
    output logic      [RESULT_W-1:0] result,
    output logic                     done
);
    logic [RESULT_W-1:0] trial_r;
    logic [RESULT_W-1:0] bit_r;

    // one comparison per step; sample is the held word from the parent's sample_r
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            trial_r <= RESULT_RESET;
            bit_r   <= '0;
            result  <= RESULT_RESET;
            done    <= 1'b0;
        end else if (start) begin
            trial_r <= {1'b1, {(RESULT_W-1){1'b0}}};
            bit_r   <= {1'b1, {(RESULT_W-1){1'b0}}};
            done    <= 1'b0;
        end else if (step && bit_r != '0) begin
            if (trial_r > sample) begin
                trial_r <= (trial_r & ~bit_r) | (bit_r >> 1);
                if (bit_r == 14'h0001) result <= trial_r & ~bit_r;
            end else begin
                trial_r <= trial_r | (bit_r >> 1);
                if (bit_r == 14'h0001) result <= trial_r;
            end
            bit_r <= bit_r >> 1;
            done  <= (bit_r == 14'h0001);
        end
    end

    chk_sar_done_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(done) |-> result == sample)
        else $error("sar result differs from sample");
endmodule
`default_nettype wire

// file: test/host_model.sv
/*
 * host serial master model: chip-select, serial clock, command bits, frame sync.
 * assumes frame then end_frame calls from the bench; sclk period 48 ns, idle low.
 */
`default_nettype none
module host_model (
    // driven link pins
    output logic      cs_n,
    output logic      sclk,
    output logic      din,
    output logic      frame_sync_in,
    // observed pins
    input  wire logic clk_sys,
    input  wire logic dout,
    input  wire logic frame_sync_out,
    input  wire logic tracking
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] cap;
    logic        fs_msb;
    logic        trk;
    int          pulses = 0;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        frame_sync_in = 1'b1;
    end
    always @(posedge clk_sys) begin
        if (frame_sync_out === 1'b1) begin
            pulses <= pulses + 1;
            fs_msb <= dout;
        end
    end
    task automatic frame(input logic dsp, input logic [7:0] cmd, input int falls);
        cap = '0;
        frame_sync_in = ~dsp;
        #3.7 cs_n = 1'b0;
        #48 frame_sync_in = 1'b1;
        // sclk held still: nothing may advance yet
        #729 trk = tracking;
        for (int f = 0; f < falls; f++) begin
            din = (f < 8) ? cmd[7-f] : ~din;
            #24 sclk = 1'b1;
            cap[f] = dout;
            #24 sclk = 1'b0;
        end
        #24 din = ~din;
    endtask
    task automatic end_frame();
        cs_n = 1'b1;
        din = ~din;
        #100;
    endtask
endmodule
`default_nettype wire

// file: test/tb_top.sv
/*
 * self-checking bench: host model drives the link, bench compares each full frame.
 * assumes the package constants and the hand-over timing of the interface.
 */
`default_nettype none
module tb_top;
    import adc_serial_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic                clk_sys;
    logic                rst_n;
    logic                transfer_width_select;
    logic                internal_clock_mode;
    logic [RESULT_W-1:0] analog_input;
    wire logic           cs_n, sclk, din, frame_sync_in, dout, dout_oe_n, eoc_n;
    wire logic           frame_sync_out, shutdown, tracking;
    wire logic [CMD_W-1:0] command;
    int                  failures, cmp_count, seed, p0;
    logic [7:0]          cmd;
    logic                dsp, wide, intc;

    adc_serial_if u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .din(din),
        .dout(dout), .dout_oe_n(dout_oe_n), .eoc_n(eoc_n), .frame_sync_in(frame_sync_in),
        .frame_sync_out(frame_sync_out), .transfer_width_select(transfer_width_select),
        .analog_input(analog_input), .internal_clock_mode(internal_clock_mode),
        .shutdown(shutdown), .tracking(tracking), .command(command));
    host_model u_host (.cs_n(cs_n), .sclk(sclk), .din(din), .frame_sync_in(frame_sync_in),
        .clk_sys(clk_sys), .dout(dout), .frame_sync_out(frame_sync_out), .tracking(tracking));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // expected dout after each falling edge: low, then msb first, then low
    function automatic logic [31:0] exp_bits(input logic [13:0] res, input logic w, input int falls);
        int e;
        exp_bits = '0;
        e = w ? 16 : 8;
        for (int n = 0; n < falls; n++) begin
            if (n >= e && n < e + 14) exp_bits[n] = res[13 - (n - e)];
        end
    endfunction

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        failures++;
        print_verdict();
    end

    initial begin
        failures = 0;
        cmp_count = 0;
        seed = 6;
        rst_n = 1'b0;
        transfer_width_select = 1'b0;
        internal_clock_mode = 1'b0;
        analog_input = '0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check({dout, eoc_n, frame_sync_out, shutdown, command}, {1'b0, EOC_RESET, 1'b0, 1'b1, CMD_RESET});
        // aborted frame first: the next full frame must start clean
        u_host.frame(1'b0, 8'hA5, 10);
        u_host.end_frame();
        for (int i = 0; i < 8; i++) begin
            {dsp, wide, intc} = i[2:0];
            cmd = $random(seed);
            @(posedge clk_sys);
            analog_input <= $random(seed);
            transfer_width_select <= wide;
            internal_clock_mode <= intc;
            @(posedge clk_sys);
            p0 = u_host.pulses;
            u_host.frame(dsp, cmd, wide ? 32 : 24);
            check(u_host.trk, 1'b1);
            check({shutdown, dout_oe_n, tracking}, 3'b000);
            check(command, cmd);
            check(eoc_n, {~intc});
            check(u_host.pulses - p0, {dsp & ~intc});
            if (dsp && !intc) check(u_host.fs_msb, analog_input[13]);
            check(u_host.cap, exp_bits(analog_input, wide, wide ? 32 : 24));
            u_host.end_frame();
            check({shutdown, dout_oe_n}, 2'b11);
            $display("test %0d done", i);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
